//--- rtl/pfcm_master.sv
// Parallel flash configuration master: link sequencer, clock gate and memory load
// Operation
// - Configuration clock comes from the 40 MHz internal oscillator.
// - Configuration clock never runs faster than 40 MHz.
// - 24-bit address output maps to flash word address lines A[24:1].
// - 16-bit data bus: flash drives on reads, device drives on writes.
// - Loader ignores flash wait during configuration; burst timing is fixed.
// - Flash starts in asynchronous read; all flash writes are asynchronous cycles.
// - Flash presents data on rising config clock; device samples accordingly.
// - Bitstream fetch is one continuous synchronous burst at 40 MHz.
// - Device drives active-low flash reset and active-low flash select.
// - Device drives active-low output enable for flash data and wait.
// - Device drives active-low address-valid strobe for addresses and writes.
// - Device drives active-low write strobe for command and data writes.
// - Configuration clock times the burst reads; command writes run with it stopped.
// - Device is sole bus master: all control, address and clock.
// - Bitstream words are loaded into internal configuration memory cells.
// - After configuration the flash stays reachable by user logic.
`timescale 1ns/1ps
module pfcm_master (
    input  wire logic                        clk_sys,
    input  wire logic                        rst_b,
    input  wire logic                        link_clk,
    input  wire logic                        chain_enable_in_b,
    input  wire logic                        reconfig_request_b,
    output logic                             config_clock,
    output logic                             flash_reset_out_b,
    output logic                             flash_select_out_b,
    output logic                             flash_output_enable_b,
    output logic                             addr_valid_strobe_b,
    output logic                             flash_write_strobe_b,
    output logic                             flash_pins_oe,
    output logic      [pfcm_pkg::ADDR_W-1:0] flash_addr,
    input  wire logic [pfcm_pkg::DATA_W-1:0] flash_data_in,
    output logic      [pfcm_pkg::DATA_W-1:0] flash_data_out,
    output logic                             flash_data_oe,
    input  wire logic                        flash_wait_in,
    input  wire logic                        user_clk_run,
    input  wire logic                        user_reset_b,
    input  wire logic                        user_select_b,
    input  wire logic                        user_output_enable_b,
    input  wire logic                        user_addr_valid_b,
    input  wire logic                        user_write_strobe_b,
    input  wire logic [pfcm_pkg::ADDR_W-1:0] user_addr,
    input  wire logic [pfcm_pkg::DATA_W-1:0] user_data_out,
    input  wire logic                        user_data_oe,
    output logic      [pfcm_pkg::DATA_W-1:0] user_data_in,
    output logic                             user_wait,
    input  wire logic [pfcm_pkg::MEM_AW-1:0] cfg_rd_addr,
    output logic      [pfcm_pkg::DATA_W-1:0] cfg_rd_data,
    output logic                             config_done,
    output logic                             config_busy
);
    ////////////////////////////////////////////////////////////////////////////
    // Link domain reset and pin synchronisers

    logic       lrst_meta_reg;
    logic       link_rst_b;
    logic [1:0] pins_sync;
    logic       chain_b_s;
    logic       reconfig_b_s;
    logic       float_req;

    // Reset asserts at once and releases on the link clock
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            lrst_meta_reg <= 1'b0;
            link_rst_b    <= 1'b0;
        end else begin
            lrst_meta_reg <= 1'b1;
            link_rst_b    <= lrst_meta_reg;
        end
    end

    pfcm_sync #(.W(2)) u_pin_sync (
        .clk   (link_clk),
        .rst_b (link_rst_b),
        .d     ({~chain_enable_in_b, reconfig_request_b}),
        .q     (pins_sync)
    );

    // Chain bit crosses inverted so the reset value reads as a float request
    assign chain_b_s    = ~pins_sync[1];
    assign reconfig_b_s = pins_sync[0];
    assign float_req    = chain_b_s & ~reconfig_b_s;

    ////////////////////////////////////////////////////////////////////////////
    // Link sequencer

    pfcm_pkg::pfcm_link_state_t   state_reg, state_next;
    logic [7:0]                   cnt_reg, cnt_next;
    logic [pfcm_pkg::MEM_AW-1:0]  word_reg, word_next;
    logic                         wr_idx_reg, wr_idx_next;
    logic                         rst_o_reg, rst_o_next;
    logic                         ce_reg, ce_next;
    logic                         oe_reg, oe_next;
    logic                         avd_reg, avd_next;
    logic                         we_reg, we_next;
    logic                         clk_run_reg, clk_run_next;
    logic                         pins_oe_reg, pins_oe_next;
    logic                         doe_reg, doe_next;
    logic [pfcm_pkg::ADDR_W-1:0]  addr_reg, addr_next;
    logic [pfcm_pkg::DATA_W-1:0]  dout_reg, dout_next;
    logic [pfcm_pkg::DATA_W-1:0]  udin_reg, udin_next;
    logic                         uwait_reg, uwait_next;
    logic                         mem_we;

    // Wait ignored during configuration: only the LS_DONE user copy reads flash wait
    always_comb begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        word_next    = word_reg;
        wr_idx_next  = wr_idx_reg;
        rst_o_next   = rst_o_reg;
        ce_next      = ce_reg;
        oe_next      = oe_reg;
        avd_next     = avd_reg;
        we_next      = we_reg;
        clk_run_next = clk_run_reg;
        doe_next     = doe_reg;
        addr_next    = addr_reg;
        dout_next    = dout_reg;
        udin_next    = udin_reg;
        uwait_next   = uwait_reg;
        pins_oe_next = ~float_req;
        case (state_reg)
            pfcm_pkg::LS_IDLE: begin
                rst_o_next   = 1'b0;
                ce_next      = 1'b1;
                oe_next      = 1'b1;
                avd_next     = 1'b1;
                we_next      = 1'b1;
                clk_run_next = 1'b0;
                doe_next     = 1'b0;
                if (!chain_b_s && reconfig_b_s) begin
                    state_next = pfcm_pkg::LS_RESET;
                    cnt_next   = 8'(pfcm_pkg::RST_CYC - 1);
                end
            end
            pfcm_pkg::LS_RESET: begin
                cnt_next = cnt_reg - 8'h01;
                if (cnt_reg == 8'h00) begin
                    rst_o_next = 1'b1;
                    state_next = pfcm_pkg::LS_RECOV;
                    cnt_next   = 8'(pfcm_pkg::RECOV_CYC - 1);
                end
            end
            pfcm_pkg::LS_RECOV: begin
                cnt_next = cnt_reg - 8'h01;
                if (cnt_reg == 8'h00) begin
                    state_next  = pfcm_pkg::LS_WR_ADDR;
                    wr_idx_next = 1'b0;
                    ce_next     = 1'b0;
                    avd_next    = 1'b0;
                    addr_next   = pfcm_pkg::RCR_ADDR;
                    dout_next   = pfcm_pkg::CMD_RCR_SETUP;
                    doe_next    = 1'b1;
                end
            end
            pfcm_pkg::LS_WR_ADDR: begin
                // Write strobe low for the pulse width
                avd_next   = 1'b1;
                we_next    = 1'b0;
                cnt_next   = 8'(pfcm_pkg::WP_CYC - 1);
                state_next = pfcm_pkg::LS_WR_PULSE;
            end
            pfcm_pkg::LS_WR_PULSE: begin
                cnt_next = cnt_reg - 8'h01;
                if (cnt_reg == 8'h00) begin
                    we_next    = 1'b1;
                    state_next = pfcm_pkg::LS_WR_HOLD;
                end
            end
            pfcm_pkg::LS_WR_HOLD: begin
                if (!wr_idx_reg) begin
                    // Second write of the command pair
                    wr_idx_next = 1'b1;
                    avd_next    = 1'b0;
                    dout_next   = pfcm_pkg::CMD_RCR_CONFIRM;
                    state_next  = pfcm_pkg::LS_WR_ADDR;
                end else begin
                    // Start address with address-valid, clock starts
                    doe_next     = 1'b0;
                    avd_next     = 1'b0;
                    addr_next    = pfcm_pkg::CFG_START_ADDR;
                    clk_run_next = 1'b1;
                    state_next   = pfcm_pkg::LS_ADDR;
                end
            end
            pfcm_pkg::LS_ADDR: begin
                // Outputs enabled after the address is latched
                avd_next   = 1'b1;
                oe_next    = 1'b0;
                cnt_next   = 8'(pfcm_pkg::BURST_LAT_CYC - 1);
                state_next = pfcm_pkg::LS_LAT;
            end
            pfcm_pkg::LS_LAT: begin
                cnt_next = cnt_reg - 8'h01;
                if (cnt_reg == 8'h00) begin
                    word_next  = '0;
                    state_next = pfcm_pkg::LS_BURST;
                end
            end
            pfcm_pkg::LS_BURST: begin
                // One word per clock, never paused
                word_next = word_reg + 1'b1;
                if (word_reg == pfcm_pkg::MEM_AW'(pfcm_pkg::CFG_WORDS - 1)) begin
                    ce_next      = 1'b1;
                    oe_next      = 1'b1;
                    clk_run_next = 1'b0;
                    state_next   = pfcm_pkg::LS_DONE;
                end
            end
            pfcm_pkg::LS_DONE: begin
                // User logic owns the flash pins
                rst_o_next   = user_reset_b;
                ce_next      = user_select_b;
                oe_next      = user_output_enable_b;
                avd_next     = user_addr_valid_b;
                we_next      = user_write_strobe_b;
                clk_run_next = user_clk_run;
                addr_next    = user_addr;
                dout_next    = user_data_out;
                doe_next     = user_data_oe;
                udin_next    = flash_data_in;
                uwait_next   = flash_wait_in;
            end
            default: begin
                state_next = pfcm_pkg::LS_IDLE;
            end
        endcase
        // Dropping the reconfig request restarts from idle in any state
        if (!reconfig_b_s) begin
            state_next = pfcm_pkg::LS_IDLE;
        end
    end

    // Link registers
    always_ff @(posedge link_clk or negedge link_rst_b) begin
        if (!link_rst_b) begin
            state_reg   <= pfcm_pkg::LS_IDLE;
            cnt_reg     <= 8'h00;
            word_reg    <= '0;
            wr_idx_reg  <= 1'b0;
            rst_o_reg   <= 1'b0;
            ce_reg      <= 1'b1;
            oe_reg      <= 1'b1;
            avd_reg     <= 1'b1;
            we_reg      <= 1'b1;
            clk_run_reg <= 1'b0;
            pins_oe_reg <= 1'b0;
            doe_reg     <= 1'b0;
            addr_reg    <= 24'h000000;
            dout_reg    <= 16'h0000;
            udin_reg    <= 16'h0000;
            uwait_reg   <= 1'b0;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            word_reg    <= word_next;
            wr_idx_reg  <= wr_idx_next;
            rst_o_reg   <= rst_o_next;
            ce_reg      <= ce_next;
            oe_reg      <= oe_next;
            avd_reg     <= avd_next;
            we_reg      <= we_next;
            clk_run_reg <= clk_run_next;
            pins_oe_reg <= pins_oe_next;
            doe_reg     <= doe_next;
            addr_reg    <= addr_next;
            dout_reg    <= dout_next;
            udin_reg    <= udin_next;
            uwait_reg   <= uwait_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pins, clock gate and memory load

    // Inverted oscillator gated by a flop that changes only while it is low
    // Never faster than the oscillator itself, so capped at 40 MHz
    assign config_clock          = ~link_clk & clk_run_reg;
    // Every control, address and data pin comes from our flops
    assign flash_reset_out_b     = rst_o_reg;
    assign flash_select_out_b    = ce_reg;
    assign flash_output_enable_b = oe_reg;
    assign addr_valid_strobe_b   = avd_reg;
    assign flash_write_strobe_b  = we_reg;
    assign flash_pins_oe         = pins_oe_reg;
    // Word address, bit 0 goes to flash A1
    assign flash_addr            = addr_reg;
    assign flash_data_out        = dout_reg;
    // Data driven only on writes and never while floating
    assign flash_data_oe         = doe_reg & pins_oe_reg;
    assign user_data_in          = udin_reg;
    assign user_wait             = uwait_reg;

    // Flash updates on rising config clock, we sample half a cycle later
    // Each burst word goes straight into configuration memory
    assign mem_we = (state_reg == pfcm_pkg::LS_BURST);

    pfcm_cfg_mem u_cfg_mem (
        .wclk  (link_clk),
        .we    (mem_we),
        .waddr (word_reg),
        .wdata (flash_data_in),
        .rclk  (clk_sys),
        .rst_b (rst_b),
        .raddr (cfg_rd_addr),
        .rdata (cfg_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Status into the system domain

    logic [1:0] stat_sys;
    logic       done_link;
    logic       busy_link;

    assign done_link = (state_reg == pfcm_pkg::LS_DONE);
    assign busy_link = (state_reg != pfcm_pkg::LS_DONE) && (state_reg != pfcm_pkg::LS_IDLE);

    // Levels only; words already cross through the dual clock memory
    pfcm_sync #(.W(2)) u_stat_sync (
        .clk   (clk_sys),
        .rst_b (rst_b),
        .d     ({done_link, busy_link}),
        .q     (stat_sys)
    );

    assign config_done = stat_sys[1];
    assign config_busy = stat_sys[0];

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the link domain

    default clocking cb_link @(posedge link_clk);
    endclocking
    default disable iff (!link_rst_b);

    AST_CLK_BURST: assert property ((state_reg == pfcm_pkg::LS_BURST) |-> clk_run_reg)
        else $error("config clock stopped during burst");
    AST_WRITE_ASYNC: assert property (!we_reg |-> !clk_run_reg)
        else $error("write strobe with config clock running");
    AST_DATA_DIR: assert property (flash_data_oe |-> oe_reg)
        else $error("data driven while flash outputs enabled");
    AST_RESET_HOLD: assert property ((state_reg != pfcm_pkg::LS_DONE) && $rose(rst_o_reg)
        |-> $past(state_reg, 4) == pfcm_pkg::LS_RESET)
        else $error("flash reset released too early");
    AST_AVD_PULSE: assert property ((state_reg == pfcm_pkg::LS_ADDR) |-> !avd_reg && !ce_reg
        && (addr_reg == pfcm_pkg::CFG_START_ADDR) ##1 avd_reg && !oe_reg)
        else $error("burst start order wrong");
    AST_OE_AFTER_AVD: assert property ((state_reg != pfcm_pkg::LS_DONE) && $fell(oe_reg)
        |-> !$past(avd_reg) && rst_o_reg && !ce_reg)
        else $error("outputs enabled without address latch");
    AST_LATENCY: assert property ((state_reg == pfcm_pkg::LS_ADDR) |-> ##5 mem_we)
        else $error("first word not sampled after latency");
    AST_BURST_LEN: assert property ($rose(mem_we) |-> mem_we [*8])
        else $error("burst load interrupted");
    AST_FLOAT: assert property (float_req |=> !flash_pins_oe && !flash_data_oe)
        else $error("bus driven while float requested");
    AST_WE_PULSE: assert property ($fell(we_reg) |-> !we_reg ##1 (!we_reg || reconfig_b_s == 1'b0))
        else $error("write strobe pulse too short");
endmodule // pfcm_master

//--- rtl/pfcm_pkg.sv
// Shared constants and types of the parallel flash configuration master
package pfcm_pkg;
    // Internal oscillator and the cap on the configuration clock
    localparam int OSC_MHZ         = 40;
    localparam int CFG_CLK_CAP_MHZ = 40;

    // Flash bus widths
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;

    // Configuration memory size, in 16-bit words
    localparam int MEM_AW    = 8;
    localparam int CFG_WORDS = 256;

    // Bitstream start word and the read configuration command pair
    localparam logic [23:0] CFG_START_ADDR  = 24'h000000;
    localparam logic [23:0] RCR_ADDR        = 24'h000000;
    localparam logic [15:0] CMD_RCR_SETUP   = 16'h0060;
    localparam logic [15:0] CMD_RCR_CONFIRM = 16'h0003;

    // Least times on the flash, in ns
    localparam int T_RST_NS   = 100;
    localparam int T_RECOV_NS = 150;
    localparam int T_WP_NS    = 50;

    // Least times rounded up to whole oscillator cycles, never below one
    localparam int RST_RAW   = (T_RST_NS * OSC_MHZ + 999) / 1000;
    localparam int RECOV_RAW = (T_RECOV_NS * OSC_MHZ + 999) / 1000;
    localparam int WP_RAW    = (T_WP_NS * OSC_MHZ + 999) / 1000;
    localparam int RST_CYC   = (RST_RAW < 1) ? 1 : RST_RAW;
    localparam int RECOV_CYC = (RECOV_RAW < 1) ? 1 : RECOV_RAW;
    localparam int WP_CYC    = (WP_RAW < 1) ? 1 : WP_RAW;

    // Cycles spent in LS_LAT; the first burst word comes 5 clock edges after the address latch
    localparam int BURST_LAT_CYC = 4;

    // Link side sequencer states
    typedef enum logic [3:0] {
        LS_IDLE,
        LS_RESET,
        LS_RECOV,
        LS_WR_ADDR,
        LS_WR_PULSE,
        LS_WR_HOLD,
        LS_ADDR,
        LS_LAT,
        LS_BURST,
        LS_DONE
    } pfcm_link_state_t;
endpackage

//--- rtl/pfcm_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
module pfcm_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // First stage is read only by the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule // pfcm_sync

//--- rtl/pfcm_cfg_mem.sv
// Configuration memory cells: written on the link clock, read on the system clock
`timescale 1ns/1ps
module pfcm_cfg_mem (
    input  wire logic                        wclk,
    input  wire logic                        we,
    input  wire logic [pfcm_pkg::MEM_AW-1:0] waddr,
    input  wire logic [pfcm_pkg::DATA_W-1:0] wdata,
    input  wire logic                        rclk,
    input  wire logic                        rst_b,
    input  wire logic [pfcm_pkg::MEM_AW-1:0] raddr,
    output logic      [pfcm_pkg::DATA_W-1:0] rdata
);
    logic [pfcm_pkg::DATA_W-1:0] mem [pfcm_pkg::CFG_WORDS];

    // Write port; reads are only meaningful once loading is reported done
    always_ff @(posedge wclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read port
    always_ff @(posedge rclk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule // pfcm_cfg_mem

//--- tb/pfcm_flash_model.sv
// Behavioural model of the 16-bit burst NOR flash that the master loads from
`timescale 1ns/1ps
module pfcm_flash_model #(
    parameter int LAT_EDGES = 5
) (
    input  wire logic        clk_cfg,
    input  wire logic        reset_b,
    input  wire logic        select_b,
    input  wire logic        oe_b,
    input  wire logic        avd_b,
    input  wire logic        we_b,
    input  wire logic [23:0] addr,
    input  wire logic [15:0] bus,
    input  wire logic [15:0] key,
    output logic      [15:0] data_drv,
    output logic             wait_out,
    output logic      [31:0] cmds,
    output logic      [23:0] lat_addr,
    output logic             seq_ok,
    output int               min_per
);
    int          cnt = 999;
    realtime     last_t = 0;
    logic [15:0] word = 16'h0;
    initial begin
        wait_out = 1'b0;
        cmds = 32'h0;
        lat_addr = 24'h0;
        seq_ok = 1'b0;
        min_per = 1000;
    end
    ////////////////////////////////////////////////////////////////
    // A 24-line part, so no extra address line or second select exists
    // Commands land at the rising write strobe, no clock involved
    always @(posedge we_b) if (select_b === 1'b0 && reset_b === 1'b1) cmds = {cmds[15:0], bus};
    // Words change on rising config clock; wait toggles as noise
    always @(posedge clk_cfg) begin
        if (last_t > 0 && int'($realtime - last_t) < min_per) min_per = int'($realtime - last_t);
        last_t = $realtime;
        if (avd_b === 1'b0) begin
            cnt = 0;
            lat_addr = addr;
            seq_ok = reset_b === 1'b1 && select_b === 1'b0 && oe_b === 1'b1;
        end else cnt = cnt + 1;
        wait_out = ~wait_out;
        word = (cnt >= LAT_EDGES && cnt < LAT_EDGES + 256) ? ({8'(cnt - LAT_EDGES), ~8'(cnt - LAT_EDGES)} ^ key) : ~word;
    end
    // A released bus shows the inverse of the last word, never a stale copy
    assign data_drv = (select_b === 1'b0 && oe_b === 1'b0) ? word : ~word;
endmodule // pfcm_flash_model

//--- tb/parallel_flash_config_master_bench.sv
// Self-checking bench for the parallel flash configuration master
`timescale 1ns/1ps
module parallel_flash_config_master_bench;
    logic        clk_sys = 0, link_clk = 0, rst_b = 0, chain_b = 1, reconf_b = 0, u_doe = 0;
    logic        u_sel_b = 1, u_oe_b = 1, u_run = 0, u_rst_b = 1, u_avd_b = 1, u_we_b = 1;
    logic [23:0] uaddr = 24'h0, faddr, lat_addr;
    logic [15:0] udout = 16'h0, key = 16'h0, fdout, fdin, drv, udin, rdata;
    logic [7:0]  raddr = 8'h0;
    logic [31:0] cmds;
    logic        cclk, fr_b, fs_b, foe_b, avd_b, we_b, pins_oe, doe, fwait, uwait, done, busy, seq_ok;
    int          err_total = 0, total_checks = 0, min_per;
    always #10 clk_sys = ~clk_sys;
    initial begin #7; forever #15 link_clk = ~link_clk; end
    assign fdin = doe ? fdout : drv;
    pfcm_master uut (.clk_sys(clk_sys), .rst_b(rst_b), .link_clk(link_clk), .chain_enable_in_b(chain_b),
        .reconfig_request_b(reconf_b), .config_clock(cclk), .flash_reset_out_b(fr_b), .flash_select_out_b(fs_b),
        .flash_output_enable_b(foe_b), .addr_valid_strobe_b(avd_b), .flash_write_strobe_b(we_b),
        .flash_pins_oe(pins_oe), .flash_addr(faddr), .flash_data_in(fdin), .flash_data_out(fdout),
        .flash_data_oe(doe), .flash_wait_in(fwait), .user_clk_run(u_run), .user_reset_b(u_rst_b),
        .user_select_b(u_sel_b), .user_output_enable_b(u_oe_b), .user_addr_valid_b(u_avd_b),
        .user_write_strobe_b(u_we_b), .user_addr(uaddr), .user_data_out(udout), .user_data_oe(u_doe),
        .user_data_in(udin), .user_wait(uwait), .cfg_rd_addr(raddr), .cfg_rd_data(rdata),
        .config_done(done), .config_busy(busy));
    pfcm_flash_model flash (.clk_cfg(cclk), .reset_b(fr_b), .select_b(fs_b), .oe_b(foe_b), .avd_b(avd_b),
        .we_b(we_b), .addr(faddr), .bus(fdin), .key(key), .data_drv(drv), .wait_out(fwait), .cmds(cmds),
        .lat_addr(lat_addr), .seq_ok(seq_ok), .min_per(min_per));
    ////////////////////////////////////////////////////////////////
    // Compare helpers and the single closing point
    task automatic chk_val(string what, logic [31:0] exp, logic [31:0] got);
        total_checks++;
        if (got !== exp) begin err_total++; $display("BAD %s exp %h got %h", what, exp, got); end
    endtask
    task automatic chk_bit(string what, logic exp, logic got);
        total_checks++;
        if (got !== exp) begin err_total++; $display("BAD %s exp %b got %b", what, exp, got); end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Word k of the burst as the flash holds it
    function automatic logic [15:0] word_of(int k, logic [15:0] kk);
        return {8'(k), ~8'(k)} ^ kk;
    endfunction
    ////////////////////////////////////////////////////////////////
    // Full load from a fresh random image, then read every cell back
    task automatic load_and_check();
        int n;
        key = 16'($urandom);
        chain_b = 0;
        reconf_b = 1;
        n = 0;
        while (done !== 1'b1 && n < 2000) begin @(posedge clk_sys); #1; n++; end
        chk_bit("done", 1'b1, done);
        chk_bit("idle busy", 1'b0, busy);
        chk_val("cmds", {pfcm_pkg::CMD_RCR_SETUP, pfcm_pkg::CMD_RCR_CONFIRM}, cmds);
        chk_val("start", 32'(pfcm_pkg::CFG_START_ADDR), 32'(lat_addr));
        chk_bit("order", 1'b1, seq_ok);
        chk_bit("cap", 1'b1, min_per >= 1000 / pfcm_pkg::CFG_CLK_CAP_MHZ);
        for (int k = 0; k < pfcm_pkg::CFG_WORDS; k++) begin
            raddr = 8'(k);
            @(posedge clk_sys); #1;
            chk_val("cfg", 32'(word_of(k, key)), 32'(rdata));
        end
    endtask
    initial begin
        repeat (40000) @(posedge clk_sys);
        err_total++;
        summarize();
    end
    // Main sequence: reset, load, user access, abort, float, reload
    initial begin
        void'($urandom(21));
        repeat (20) @(posedge clk_sys);
        #1;
        chk_bit("rst out", 1'b0, fr_b);
        chk_bit("pins oe", 1'b0, pins_oe);
        rst_b = 1;
        load_and_check();
        uaddr = 24'($urandom);
        udout = 16'($urandom);
        u_sel_b = 0;
        u_doe = 1;
        u_we_b = 0;
        repeat (4) @(posedge link_clk); #1;
        chk_val("uaddr", 32'(uaddr), 32'(faddr));
        chk_bit("usel", 1'b0, fs_b);
        chk_bit("uwe", 1'b0, we_b);
        chk_bit("udoe", 1'b1, doe);
        chk_val("udata", 32'(udout), 32'(fdout));
        u_doe = 0;
        u_we_b = 1;
        u_oe_b = 0;
        u_run = 1;
        repeat (4) @(posedge link_clk); #1;
        chk_val("udin", 32'(fdin), 32'(udin));
        chk_bit("uwait", fwait, uwait);
        u_sel_b = 1;
        u_oe_b = 1;
        u_run = 0;
        reconf_b = 0;
        repeat (8) @(posedge link_clk); #1;
        reconf_b = 1;
        repeat (160) @(posedge link_clk); #1;
        chk_bit("busy", 1'b1, busy);
        reconf_b = 0;
        repeat (5) @(posedge link_clk); #1;
        chk_bit("abort rst", 1'b0, fr_b);
        chk_bit("abort sel", 1'b1, fs_b);
        chain_b = 1;
        repeat (5) @(posedge link_clk); #1;
        chk_bit("float", 1'b0, pins_oe);
        chk_bit("float data", 1'b0, doe);
        load_and_check();
        summarize();
    end
endmodule // parallel_flash_config_master_bench
